// ---- verilog/mcra_pkg.sv ----
// Constants and types for the compare, move, reverse and parallel add datapath.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
//
// Contract
// - Compare subtracts, sets all flags, no write.
// - Compare-negative adds, sets flags, discards sum.
// - Comparisons always update all four flags.
// - Move copies shifted second operand to destination.
// - Wide move loads 16-bit immediate, zero extended.
// - Move by register shift equals shift operation.
// - Move-not writes the inverted second operand.
// - Move to PC branches with bit0 cleared.
// - Flagged move sets N,Z, shifter C, keeps V.
// - Move-top writes upper half, keeps lower, flags.
// - Word reverse swaps four bytes end for end.
// - Halfword reverse swaps bytes within each halfword.
// - Signed halfword reverse swaps, then sign-extends.
// - Bit reverse maps bit i to 31-i.
// - Reversals leave all flags unchanged.
// - Halfword parallel add, two independent signed lanes.
// - Byte parallel add, four independent signed lanes.
// - Halving adds shift each lane sum right once.

package mcra_pkg;

    // APB register offsets (byte addresses)
    localparam logic [7:0] MCRA_FLAGS_ADDR = 8'h00;
    localparam logic [7:0] MCRA_LAST_RESULT_ADDR = 8'h04;

    // Field positions of the flag register
    localparam int MCRA_FLAG_N_BIT = 3;
    localparam int MCRA_FLAG_Z_BIT = 2;
    localparam int MCRA_FLAG_C_BIT = 1;
    localparam int MCRA_FLAG_V_BIT = 0;

    // Values after reset
    localparam logic [31:0] MCRA_WORD_RESET = 32'h0000_0000;
    localparam logic [3:0] MCRA_FLAGS_RESET = 4'h0;

    // Register numbers with special meaning
    localparam logic [3:0] MCRA_REG_SP = 4'hd;
    localparam logic [3:0] MCRA_REG_PC = 4'hf;

    // Operations
    typedef enum logic [3:0] {
        compare_op,
        compare_negative_op,
        register_move_op,
        move_not_op,
        wide_move_alias,
        move_top_op,
        word_byte_reverse,
        halfword_byte_reverse,
        signed_halfword_reverse,
        bit_reverse,
        parallel_signed_halfword_add,
        parallel_signed_byte_add,
        halving_halfword_add,
        halving_byte_add
    } mcra_op_t;

    // Shift applied to the flexible second operand
    typedef enum logic [2:0] {
        shift_none,
        logic_shift_left,
        logic_shift_right,
        arith_shift_right,
        rotate_right,
        rotate_right_extend
    } mcra_shift_t;

endpackage

// ---- verilog/mcra_alu.sv ----
// Integer datapath: compare, move, move-top, reversals, parallel signed adds.
// Assumes decoder and register file on the same clock; one request per cycle.
`timescale 1ns/100ps

module mcra_alu
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request from the decoder
    input wire logic req_valid,
    input wire mcra_pkg::mcra_op_t req_op,
    input wire logic [31:0] first_operand,
    input wire logic [31:0] second_operand,
    input wire mcra_pkg::mcra_shift_t shift_kind,
    input wire logic [7:0] shift_amount,
    input wire logic set_flags,
    input wire logic [3:0] first_sel,
    input wire logic [3:0] dest_sel,
    input wire logic dest_present,
    input wire logic [31:0] dest_old,
    // Result to the register file
    output logic result_valid,
    output logic result_wr_en,
    output logic [3:0] result_dest,
    output logic [31:0] result,
    output logic branch_valid,
    output logic [31:0] branch_target,
    // Condition flags
    output logic flag_n,
    output logic flag_z,
    output logic flag_c,
    output logic flag_v,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import mcra_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic result_valid;
        logic result_wr_en;
        logic [3:0] result_dest;
        logic [31:0] result;
        logic branch_valid;
        logic [31:0] branch_target;
        logic [3:0] flags;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mcra_state_t;

    mcra_state_t cur;
    mcra_state_t next_cur;

    ////////////////////////////////////////////////////////////////////////
    // Operand shifter for the move forms
    function automatic logic [32:0] mcra_shift(input logic [31:0] val, input mcra_shift_t kind,
                                               input logic [7:0] amt, input logic cin);
        logic [63:0] wide;
        logic [31:0] rot;
        logic [32:0] res;
        wide = 64'h0000_0000_0000_0000;
        rot = 32'h0000_0000;
        res = {cin, val};
        case (kind)
            logic_shift_left:
            begin
                wide = {32'h0000_0000, val} << amt;
                if (amt == 8'h00)
                    res = {cin, val};
                else if (amt <= 8'h20)
                    res = {wide[32], wide[31:0]};
                else
                    res = {1'b0, 32'h0000_0000};
            end
            logic_shift_right:
            begin
                wide = {val, 32'h0000_0000} >> amt;
                if (amt == 8'h00)
                    res = {cin, val};
                else if (amt <= 8'h20)
                    res = {wide[31], wide[63:32]};
                else
                    res = {1'b0, 32'h0000_0000};
            end
            arith_shift_right:
            begin
                wide = $signed({val, 32'h0000_0000}) >>> amt;
                if (amt == 8'h00)
                    res = {cin, val};
                else if (amt < 8'h20)
                    res = {wide[31], wide[63:32]};
                else
                    res = {val[31], {32{val[31]}}};
            end
            rotate_right:
            begin
                rot = (val >> amt[4:0]) | (val << (6'd32 - {1'b0, amt[4:0]}));
                if (amt == 8'h00)
                    res = {cin, val};
                else
                    res = {rot[31], rot};
            end
            rotate_right_extend:
                res = {val[0], cin, val[31:1]};
            default:
                res = {cin, val};
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic for the comparisons
    logic [32:0] diff;
    logic [32:0] sum;
    logic diff_v;
    logic sum_v;

    assign diff = {1'b0, first_operand} + {1'b0, ~second_operand} + 33'h0_0000_0001;
    assign sum = {1'b0, first_operand} + {1'b0, second_operand};
    assign diff_v = (first_operand[31] != second_operand[31]) && (diff[31] != first_operand[31]);
    assign sum_v = (first_operand[31] == second_operand[31]) && (sum[31] != first_operand[31]);

    ////////////////////////////////////////////////////////////////////////
    // Parallel lanes, each with its own sign bit and no carry between them
    logic [16:0] half_sum [2];
    logic [8:0] byte_sum [4];
    logic [31:0] padd16;
    logic [31:0] phadd16;
    logic [31:0] padd8;
    logic [31:0] phadd8;
    logic [31:0] bits_rev;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_half
            assign half_sum[g] = {first_operand[16*g+15], first_operand[16*g +: 16]} +
                                 {second_operand[16*g+15], second_operand[16*g +: 16]};
            assign padd16[16*g +: 16] = half_sum[g][15:0];
            assign phadd16[16*g +: 16] = half_sum[g][16:1];
        end
        for (g = 0; g < 4; g++)
        begin : g_byte
            assign byte_sum[g] = {first_operand[8*g+7], first_operand[8*g +: 8]} +
                                 {second_operand[8*g+7], second_operand[8*g +: 8]};
            assign padd8[8*g +: 8] = byte_sum[g][7:0];
            assign phadd8[8*g +: 8] = byte_sum[g][8:1];
        end
        for (g = 0; g < 32; g++)
        begin : g_bit
            assign bits_rev[g] = first_operand[31-g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [32:0] shifted;
        logic [31:0] value;
        logic [3:0] dest;
        shifted = mcra_shift(second_operand, shift_kind, shift_amount, cur.flags[MCRA_FLAG_C_BIT]);
        value = MCRA_WORD_RESET;
        dest = dest_present ? dest_sel : first_sel;
        next_cur = cur;
        next_cur.result_valid = 1'b0;
        next_cur.result_wr_en = 1'b0;
        next_cur.branch_valid = 1'b0;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;

        // APB: one wait state, then answer
        if (psel && penable && !cur.pready)
        begin
            next_cur.pready = 1'b1;
            next_cur.prdata = MCRA_WORD_RESET;
            case (paddr)
                MCRA_FLAGS_ADDR:
                begin
                    if (!pwrite)
                        next_cur.prdata = {28'h000_0000, cur.flags};
                end
                MCRA_LAST_RESULT_ADDR:
                begin
                    if (!pwrite)
                        next_cur.prdata = cur.result;
                end
                default:
                    next_cur.pslverr = 1'b1;
            endcase
        end

        // A flag write lands only on the edge that completes the transfer
        if (psel && penable && pwrite && cur.pready && paddr == MCRA_FLAGS_ADDR)
        begin
            next_cur.flags = pwdata[3:0];
        end

        // Datapath; a flag update here wins over an APB write
        if (req_valid)
        begin
            next_cur.result_valid = 1'b1;
            next_cur.result_wr_en = 1'b1;
            next_cur.result_dest = dest;
            case (req_op)
                compare_op:
                begin
                    value = diff[31:0];
                    next_cur.result_wr_en = 1'b0;
                    next_cur.flags = {diff[31], diff[31:0] == 32'h0000_0000, diff[32], diff_v};
                end
                compare_negative_op:
                begin
                    value = sum[31:0];
                    next_cur.result_wr_en = 1'b0;
                    next_cur.flags = {sum[31], sum[31:0] == 32'h0000_0000, sum[32], sum_v};
                end
                register_move_op, move_not_op:
                begin
                    value = (req_op == move_not_op) ? ~shifted[31:0] : shifted[31:0];
                    if (set_flags)
                    begin
                        next_cur.flags[MCRA_FLAG_N_BIT] = value[31];
                        next_cur.flags[MCRA_FLAG_Z_BIT] = (value == 32'h0000_0000);
                        next_cur.flags[MCRA_FLAG_C_BIT] = shifted[32];
                    end
                    if (req_op == register_move_op && dest == MCRA_REG_PC)
                    begin
                        next_cur.result_wr_en = 1'b0;
                        next_cur.branch_valid = 1'b1;
                        next_cur.branch_target = {value[31:1], 1'b0};
                    end
                end
                wide_move_alias:
                    value = {16'h0000, second_operand[15:0]};
                move_top_op:
                    value = {second_operand[15:0], dest_old[15:0]};
                word_byte_reverse:
                    value = {first_operand[7:0], first_operand[15:8], first_operand[23:16],
                             first_operand[31:24]};
                halfword_byte_reverse:
                    value = {first_operand[23:16], first_operand[31:24], first_operand[7:0],
                             first_operand[15:8]};
                signed_halfword_reverse:
                    value = {{16{first_operand[7]}}, first_operand[7:0], first_operand[15:8]};
                bit_reverse:
                    value = bits_rev;
                parallel_signed_halfword_add:
                    value = padd16;
                parallel_signed_byte_add:
                    value = padd8;
                halving_halfword_add:
                    value = phadd16;
                halving_byte_add:
                    value = phadd8;
                default:
                    next_cur.result_wr_en = 1'b0;
            endcase
            next_cur.result = value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cur.result_valid <= 1'b0;
            cur.result_wr_en <= 1'b0;
            cur.result_dest <= 4'h0;
            cur.result <= MCRA_WORD_RESET;
            cur.branch_valid <= 1'b0;
            cur.branch_target <= MCRA_WORD_RESET;
            cur.flags <= MCRA_FLAGS_RESET;
            cur.prdata <= MCRA_WORD_RESET;
            cur.pready <= 1'b0;
            cur.pslverr <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign result_valid = cur.result_valid;
    assign result_wr_en = cur.result_wr_en;
    assign result_dest = cur.result_dest;
    assign result = cur.result;
    assign branch_valid = cur.branch_valid;
    assign branch_target = cur.branch_target;
    assign flag_n = cur.flags[MCRA_FLAG_N_BIT];
    assign flag_z = cur.flags[MCRA_FLAG_Z_BIT];
    assign flag_c = cur.flags[MCRA_FLAG_C_BIT];
    assign flag_v = cur.flags[MCRA_FLAG_V_BIT];
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;

endmodule // mcra_alu

// ---- bench/mcra_alu_chk.sv ----
// Assertion checker on the datapath ports.
// Assumes binding to every mcra_alu instance.
`timescale 1ns/100ps

module mcra_alu_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request side
    input wire logic req_valid,
    input wire mcra_pkg::mcra_op_t req_op,
    input wire logic [31:0] first_operand,
    input wire logic [31:0] second_operand,
    input wire mcra_pkg::mcra_shift_t shift_kind,
    input wire logic [3:0] dest_sel,
    input wire logic dest_present,
    input wire logic [31:0] dest_old,
    input wire logic psel,
    // Result side
    input wire logic result_valid,
    input wire logic result_wr_en,
    input wire logic [31:0] result,
    input wire logic branch_valid,
    input wire logic [31:0] branch_target,
    input wire logic flag_n,
    input wire logic flag_z,
    input wire logic flag_c,
    input wire logic flag_v
);
    import mcra_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Bit-reversed first operand for the reverse check
    logic [31:0] first_rev;
    always_comb first_rev = {<<{first_operand}};
    ////////////////////////////////////////
    // Timing, compares and moves
    answer_time_a: assert property (req_valid |=> result_valid) else $error("late result");
    compare_no_write_a: assert property (req_valid && req_op inside {compare_op, compare_negative_op}
        |=> !result_wr_en) else $error("compare wrote");
    compare_zero_a: assert property (req_valid && req_op == compare_op
        |=> flag_z == ($past(first_operand) == $past(second_operand))) else $error("compare zero flag");
    negcompare_zero_a: assert property (req_valid && req_op == compare_negative_op
        |=> flag_z == ($past(first_operand) + $past(second_operand) == 32'h0000_0000))
        else $error("compare-negative zero flag");
    invert_move_a: assert property (req_valid && req_op == move_not_op && shift_kind == shift_none
        |=> result == ~$past(second_operand)) else $error("move-not value");
    move_keep_v_a: assert property (req_valid && req_op inside {register_move_op, move_not_op} && !psel
        |=> $stable(flag_v)) else $error("move changed overflow");
    pc_branch_a: assert property (req_valid && req_op == register_move_op && dest_present && dest_sel == MCRA_REG_PC
        |=> branch_valid && !result_wr_en && !branch_target[0]) else $error("bad branch");
    move_top_a: assert property (req_valid && req_op == move_top_op
        |=> result == {$past(second_operand[15:0]), $past(dest_old[15:0])}) else $error("move-top value");
    ////////////////////////////////////////
    // Reversals and lanes
    bit_rev_a: assert property (req_valid && req_op == bit_reverse
        |=> result == $past(first_rev)) else $error("bit reverse value");
    rev_flags_a: assert property (req_valid && req_op inside {[word_byte_reverse:halving_byte_add]} && !psel
        |=> $stable({flag_n, flag_z, flag_c, flag_v})) else $error("flags moved");
    half_lane_a: assert property (req_valid && req_op == parallel_signed_halfword_add
        |=> result[15:0] == $past(first_operand[15:0]) + $past(second_operand[15:0])) else $error("low lane");
endmodule // mcra_alu_chk

bind mcra_alu mcra_alu_chk chk_u (.clk, .srst, .req_valid, .req_op, .first_operand, .second_operand,
    .shift_kind, .dest_sel, .dest_present, .dest_old, .psel, .result_valid, .result_wr_en, .result,
    .branch_valid, .branch_target, .flag_n, .flag_z, .flag_c, .flag_v);

// ---- bench/mcra_regfile.sv ----
// Register file model that feeds and takes back datapath words.
// Assumes write-back comes from the datapath result port.
`timescale 1ns/100ps

module mcra_regfile
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Write-back
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [31:0] wr_data,
    // Read port
    input wire logic [3:0] rd_sel,
    output logic [31:0] rd_data
);
    logic [31:0] regs [16];
    // Store written results
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            regs <= '{default: '0};
        end
        else if (wr_en)
        begin
            regs[wr_sel] <= wr_data;
        end
    end
    // Current destination value
    assign rd_data = regs[rd_sel];
endmodule // mcra_regfile

// ---- bench/move_compare_reverse_simd_add_alu_tb.sv ----
// Self-checking bench for the datapath with a register file model.
// Assumes the checker is bound to the datapath.
`timescale 1ns/100ps

module move_compare_reverse_simd_add_alu_tb;
    import mcra_pkg::*;
    typedef struct {mcra_op_t op; logic [31:0] a; logic [31:0] b; mcra_shift_t sk; logic sf;
        logic [31:0] res; logic [3:0] fl;} mcra_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    mcra_op_t req_op = compare_op;
    logic [31:0] first_operand = '0;
    logic [31:0] second_operand = '0;
    mcra_shift_t shift_kind = shift_none;
    logic [7:0] shift_amount = 8'h04;
    logic set_flags = 1'b0;
    logic [3:0] first_sel = 4'h3;
    logic [3:0] dest_sel = 4'h2;
    logic dest_present = 1'b1;
    logic [3:0] rd_sel = 4'h2;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = '0;
    logic result_valid, result_wr_en, branch_valid, pready, pslverr, flag_n, flag_z, flag_c, flag_v;
    logic [3:0] result_dest;
    logic [31:0] result, branch_target, prdata, dest_old, rdata;
    int miscompares = 0;
    int checked = 0;
    mcra_row_t rows [18];

    // Clock, 10 ns period
    initial forever #5 clk = ~clk;

    mcra_alu dut_u (.clk, .srst, .req_valid, .req_op, .first_operand, .second_operand, .shift_kind,
        .shift_amount, .set_flags, .first_sel, .dest_sel, .dest_present, .dest_old, .result_valid,
        .result_wr_en, .result_dest, .result, .branch_valid, .branch_target, .flag_n, .flag_z, .flag_c,
        .flag_v, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    mcra_regfile rf_u (.clk, .srst, .wr_en(result_wr_en), .wr_sel(result_dest), .wr_data(result),
        .rd_sel, .rd_data(dest_old));

    ////////////////////////////////////////
    // Verdict and comparison
    task automatic close_out;
        if (miscompares == 0 && checked > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // One request, checked one cycle later
    task automatic issue(input mcra_op_t op, input logic [31:0] a, input logic [31:0] b,
        input mcra_shift_t sk, input logic sf, input logic [3:0] ds, input logic dp,
        input logic [7:0] sa = 8'h04);
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        first_operand <= a;
        second_operand <= b;
        shift_kind <= sk;
        shift_amount <= sa;
        set_flags <= sf;
        dest_sel <= ds;
        dest_present <= dp;
        rd_sel <= dp ? ds : first_sel;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        chk("result valid", 32'h1, {31'h0, result_valid});
    endtask

    // APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Watchdog
    initial
    begin
        repeat (2000) @(posedge clk);
        miscompares++;
        close_out();
    end

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic err;
        rows = '{'{compare_op, 32'h0000_0005, 32'h0000_0005, shift_none, 1'b0, '0, 4'h6},
            '{compare_op, 32'h8000_0000, 32'h0000_0001, shift_none, 1'b0, 32'h7FFF_FFFF, 4'h3},
            '{compare_negative_op, 32'hFFFF_FFFF, 32'h0000_0001, shift_none, 1'b0, '0, 4'h6},
            '{move_not_op, '0, 32'h0000_000F, shift_none, 1'b1, 32'hFFFF_FFF0, 4'hA},
            '{compare_negative_op, 32'h7FFF_FFFF, 32'h0000_0001, shift_none, 1'b0, 32'h8000_0000, 4'h9},
            '{register_move_op, '0, 32'h1000_0000, logic_shift_left, 1'b1, '0, 4'h7},
            '{register_move_op, '0, 32'h1234_5678, rotate_right, 1'b0, 32'h8123_4567, 4'h7},
            '{register_move_op, '0, 32'h8000_0000, arith_shift_right, 1'b0, 32'hF800_0000, 4'h7},
            '{wide_move_alias, '0, 32'h0000_FFFF, shift_none, 1'b0, 32'h0000_FFFF, 4'h7},
            '{word_byte_reverse, 32'h1122_3344, '0, shift_none, 1'b0, 32'h4433_2211, 4'h7},
            '{halfword_byte_reverse, 32'h1122_3344, '0, shift_none, 1'b0, 32'h2211_4433, 4'h7},
            '{signed_halfword_reverse, 32'h0000_1280, '0, shift_none, 1'b0, 32'hFFFF_8012, 4'h7},
            '{bit_reverse, 32'h0000_000F, '0, shift_none, 1'b0, 32'hF000_0000, 4'h7},
            '{parallel_signed_halfword_add, 32'h7FFF_FFFF, 32'h0001_0001, shift_none, 1'b0, 32'h8000_0000, 4'h7},
            '{parallel_signed_byte_add, 32'h7FFF_80FF, 32'h0101_8001, shift_none, 1'b0, 32'h8000_0000, 4'h7},
            '{halving_halfword_add, 32'h7FFF_8000, 32'h7FFF_8000, shift_none, 1'b0, 32'h7FFF_8000, 4'h7},
            '{halving_byte_add, 32'h7F80_0102, 32'h7F80_0304, shift_none, 1'b0, 32'h7F80_0203, 4'h7},
            '{register_move_op, '0, 32'h0000_0003, rotate_right_extend, 1'b1, 32'h8000_0001, 4'hB}};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].a, rows[i].b, rows[i].sk, rows[i].sf, 4'h2, 1'b1);
            chk("result", rows[i].res, result);
            chk("flags", {28'h0, rows[i].fl}, {28'h0, flag_n, flag_z, flag_c, flag_v});
        end
        // Move-top keeps the low half written just before
        issue(wide_move_alias, '0, 32'h0000_FA05, shift_none, 1'b0, 4'h1, 1'b1);
        issue(move_top_op, '0, 32'h0000_F123, shift_none, 1'b0, 4'h1, 1'b1);
        @(posedge clk);
        #1;
        chk("move top", 32'hF123_FA05, dest_old);
        // Omitted destination falls back on the first register
        issue(parallel_signed_halfword_add, 32'h0001_0002, 32'h0003_0004, shift_none, 1'b0, 4'h2, 1'b0);
        chk("dest", 32'h3, {28'h0, result_dest});
        @(posedge clk);
        #1;
        chk("fallback reg", 32'h0004_0006, dest_old);
        // Move to the program counter
        issue(register_move_op, '0, 32'h0000_1235, shift_none, 1'b0, 4'hf, 1'b1);
        chk("branch target", 32'h0000_1234, branch_target);
        chk("branch strobes", 32'h2, {30'h0, branch_valid, result_wr_en});
        // Register shift right by 32, then by 33
        issue(register_move_op, '0, 32'h8000_0001, logic_shift_right, 1'b1, 4'h2, 1'b1, 8'h20);
        chk("result", 32'h0, result);
        chk("flags", 32'h7, {28'h0, flag_n, flag_z, flag_c, flag_v});
        issue(register_move_op, '0, 32'h8000_0001, logic_shift_right, 1'b1, 4'h2, 1'b1, 8'h21);
        chk("flags", 32'h5, {28'h0, flag_n, flag_z, flag_c, flag_v});
        // Flag register over APB, unmapped address, then reset
        apb(1'b1, 8'h00, 32'h0000_000A, err);
        apb(1'b0, 8'h00, '0, err);
        chk("flag reg", 32'h0000_000A, rdata);
        apb(1'b0, 8'h08, '0, err);
        chk("slave error", 32'h1, {31'h0, err});
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("reset state", '0, {result[31:4], flag_n, flag_z, flag_c, flag_v});
        chk("reset target", 32'h0, branch_target);
        close_out();
    end
endmodule // move_compare_reverse_simd_add_alu_tb
